// [design/dpa_pkg.sv]
// Shared constants and types for the display RAM access pointer block.
// Assumes one core clock; host port pins are sampled synchronously.
package dpa_pkg;
    // Geometry
    localparam int          DPA_COL_W        = 7;
    localparam int          DPA_PAGE_W       = 3;
    localparam logic [6:0]  DPA_COL_LAST     = 7'h7f;
    localparam logic [2:0]  DPA_PAGE_LAST    = 3'h4;
    // Addressing modes
    localparam logic [1:0]  DPA_MODE_HORIZ   = 2'h0;
    localparam logic [1:0]  DPA_MODE_VERT    = 2'h1;
    localparam logic [1:0]  DPA_MODE_PAGE    = 2'h2;
    localparam logic [1:0]  DPA_MODE_BAD     = 2'h3;
    // Opcodes
    localparam logic [7:0]  DPA_OP_NOP       = 8'he3;
    localparam logic [7:0]  DPA_OP_MODE      = 8'h20;
    localparam logic [7:0]  DPA_OP_COLWIN    = 8'h21;
    localparam logic [7:0]  DPA_OP_PAGEWIN   = 8'h22;
    localparam logic [7:0]  DPA_OP_CONTRAST  = 8'h81;
    localparam logic [7:0]  DPA_OP_DISP_OFF  = 8'hae;
    localparam logic [7:0]  DPA_OP_DISP_ON   = 8'haf;
    localparam logic [7:0]  DPA_OP_LOCOL_HI  = 8'h0f;
    localparam logic [7:0]  DPA_OP_HICOL_LO  = 8'h10;
    localparam logic [7:0]  DPA_OP_HICOL_HI  = 8'h17;
    localparam logic [7:0]  DPA_OP_PAGE_LO   = 8'hb0;
    localparam logic [7:0]  DPA_OP_PAGE_HI   = 8'hb4;
    localparam logic [7:0]  DPA_OP_LINE_LO   = 8'h40;
    localparam logic [7:0]  DPA_OP_LINE_HI   = 8'h66;
    // Status byte layout
    localparam int          DPA_STAT_OFF_BIT = 6;
    // Reset values
    localparam logic [7:0]  DPA_RST_CONTRAST = 8'h7f;
    localparam logic [5:0]  DPA_RST_LINE     = 6'h00;
    // Command decoder states
    typedef enum logic {DPA_CMD_OPCODE, DPA_CMD_PARAM} dpa_cmd_state_t;
endpackage

// [design/dpa_host_strobe.sv]
// Host port strobe detector: turns parallel or serial bus activity into
// one-cycle write and read pulses. Assumes pins synchronous to i_core_clk.
`timescale 1ns/1ps
`default_nettype none
module dpa_host_strobe (
    // Clock and reset
    input  wire logic i_core_clk,
    input  wire logic i_rst_n,
    // Port configuration
    input  wire logic i_serial_mode,
    input  wire logic i_bus_8080,
    // Parallel pins
    input  wire logic i_cs_n,
    input  wire logic i_rw,
    input  wire logic i_e,
    input  wire logic i_wr_n,
    input  wire logic i_rd_n,
    // Serial byte strobe
    input  wire logic i_ser_valid,
    // Pulses
    output logic      o_wr_pulse,
    output logic      o_rd_pulse,
    output logic      o_rd_active
);
    // -------------------------------------------------------------
    // Edge history
    // -------------------------------------------------------------
    typedef struct packed {
        logic e;
        logic wr_n;
        logic rd_n;
    } dpa_strobe_st_t;

    dpa_strobe_st_t st_reg;
    dpa_strobe_st_t st_next;

    // Sample previous levels
    always_comb begin
        st_next      = st_reg;
        st_next.e    = i_e;
        st_next.wr_n = i_wr_n;
        st_next.rd_n = i_rd_n;
    end

    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            st_reg <= '{e: 1'b0, wr_n: 1'b1, rd_n: 1'b1};
        end else begin
            st_reg <= st_next;
        end
    end

    // Write on strobe release, read on strobe assertion
    always_comb begin
        o_wr_pulse  = 1'b0;
        o_rd_pulse  = 1'b0;
        o_rd_active = 1'b0;
        if (i_serial_mode) begin
            o_wr_pulse = i_ser_valid;  // Serial is write only
        end else if (!i_cs_n) begin
            if (i_bus_8080) begin
                o_wr_pulse  = i_wr_n && !st_reg.wr_n;
                o_rd_pulse  = !i_rd_n && st_reg.rd_n;
                o_rd_active = !i_rd_n;
            end else begin
                o_wr_pulse  = !i_e && st_reg.e && !i_rw;
                o_rd_pulse  = i_e && !st_reg.e && i_rw;
                o_rd_active = i_e && i_rw;
            end
        end
    end
endmodule
`default_nettype wire

// [design/dpa_ptr_step.sv]
// Next column and page pointer after one data access, per addressing mode.
// Purely combinational; the caller registers the result.
`timescale 1ns/1ps
`default_nettype none
module dpa_ptr_step
    import dpa_pkg::*;
(
    // Mode and current pointers
    input  wire logic [1:0] i_mode,
    input  wire logic [6:0] i_col,
    input  wire logic [2:0] i_page,
    // Windows
    input  wire logic [6:0] i_col_start,
    input  wire logic [6:0] i_col_end,
    input  wire logic [2:0] i_page_start,
    input  wire logic [2:0] i_page_end,
    // Next pointers
    output logic      [6:0] o_col,
    output logic      [2:0] o_page
);
    logic col_at_end;
    logic page_at_end;

    // Step and wrap
    always_comb begin
        col_at_end  = (i_col == i_col_end);
        page_at_end = (i_page == i_page_end);
        o_col       = i_col;
        o_page      = i_page;
        case (i_mode)
            DPA_MODE_HORIZ: begin
                o_col = col_at_end ? i_col_start : i_col + 7'h01;
                if (col_at_end) begin
                    o_page = page_at_end ? i_page_start : i_page + 3'h1;
                end
            end
            DPA_MODE_VERT: begin
                o_page = page_at_end ? i_page_start : i_page + 3'h1;
                if (page_at_end) begin
                    o_col = col_at_end ? i_col_start : i_col + 7'h01;
                end
            end
            default: begin
                o_col = col_at_end ? i_col_start : i_col + 7'h01;
            end
        endcase
    end
endmodule
`default_nettype wire

// [design/dpa_core.sv]
// Display RAM access pointer: command decoder, pointer keeper, data path.
// Assumes a display RAM with one-cycle read latency on the far side.
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - Opcode E3h as a command changes nothing.
// - Status read returns bit 6 set while display off, other bits zero.
// - Serial port gives no reads; every transfer is a write.
// - Each data read advances the column pointer, or the page pointer in vertical mode.
// - First read after a pointer load returns dummy data.
// - Data write with select high advances the column pointer, or the page pointer in vertical mode.
// - Status reads never move the pointers; data accesses and pointer-load commands do.
// - Opcodes 00h-0Fh load low nibble of page-mode column start.
// - Opcodes 10h-17h load high bits of page-mode column start.
// - Page mode: column steps, wraps to start, page stays.
// - Horizontal mode: column steps, page steps on column wrap, both wrap.
// - Vertical mode: page steps, column steps on page wrap, both wrap.
// - Opcodes B0h-B4h set page pointer to page 0-4.
// - 21h plus two bytes sets column window and loads column pointer.
// - 22h plus two bytes sets page window and loads page pointer.
// - Opcodes 40h-66h set display start line 0-38.
// - 81h plus one byte sets the contrast step.
// - Mode codes: horizontal 00, vertical 01, page 10 at reset, 11 ignored.
module dpa_core
    import dpa_pkg::*;
(
    // Clock and reset
    input  wire logic                 i_core_clk,
    input  wire logic                 i_rst_n,
    // Port configuration
    input  wire logic                 i_serial_mode,
    input  wire logic                 i_bus_8080,
    // Host pins
    input  wire logic                 i_cs_n,
    input  wire logic                 i_dc,
    input  wire logic                 i_rw,
    input  wire logic                 i_e,
    input  wire logic                 i_wr_n,
    input  wire logic                 i_rd_n,
    input  wire logic [7:0]           i_data,
    output logic      [7:0]           o_data,
    output logic                      o_data_oe,
    // Serial byte input
    input  wire logic                 i_ser_valid,
    input  wire logic [7:0]           i_ser_data,
    // Display RAM port
    output logic                      o_ram_we,
    output logic                      o_ram_re,
    output logic [dpa_pkg::DPA_COL_W-1:0]  o_ram_col,
    output logic [dpa_pkg::DPA_PAGE_W-1:0] o_ram_page,
    output logic      [7:0]           o_ram_wdata,
    input  wire logic [7:0]           i_ram_rdata,
    // Display settings
    output logic      [1:0]           o_addr_mode,
    output logic      [5:0]           o_start_line,
    output logic      [7:0]           o_contrast,
    output logic                      o_display_on
);
    import dpa_pkg::*;

    // -------------------------------------------------------------
    // State
    // -------------------------------------------------------------
    typedef struct packed {
        dpa_cmd_state_t cst;
        logic [7:0]     op;
        logic [2:0]     pidx;
        logic [2:0]     ptot;
        logic [7:0]     p1;
        logic [1:0]     mode;
        logic [6:0]     col;
        logic [2:0]     page;
        logic [6:0]     col_start;
        logic [6:0]     col_end;
        logic [2:0]     page_start;
        logic [2:0]     page_end;
        logic [5:0]     line;
        logic [7:0]     contrast;
        logic           disp_on;
        logic [7:0]     rd_buf;
        logic           re_pend;
        logic           ram_we;
        logic           ram_re;
        logic [6:0]     ram_col;
        logic [2:0]     ram_page;
        logic [7:0]     ram_wdata;
        logic [7:0]     dout;
        logic           dout_oe;
    } dpa_core_st_t;

    dpa_core_st_t st_reg;
    dpa_core_st_t st_next;

    logic       wr_p;
    logic       rd_p;
    logic       rd_act;
    logic [7:0] wbyte;
    logic [6:0] step_col;
    logic [2:0] step_page;
    logic       cmd_wr;
    logic       dat_wr;
    logic       dat_rd;
    logic       stat_rd;

    // -------------------------------------------------------------
    // Host strobes and pointer stepper
    // -------------------------------------------------------------
    dpa_host_strobe u_strobe (
        .i_core_clk    (i_core_clk),
        .i_rst_n       (i_rst_n),
        .i_serial_mode (i_serial_mode),
        .i_bus_8080    (i_bus_8080),
        .i_cs_n        (i_cs_n),
        .i_rw          (i_rw),
        .i_e           (i_e),
        .i_wr_n        (i_wr_n),
        .i_rd_n        (i_rd_n),
        .i_ser_valid   (i_ser_valid),
        .o_wr_pulse    (wr_p),
        .o_rd_pulse    (rd_p),
        .o_rd_active   (rd_act)
    );

    dpa_ptr_step u_step (
        .i_mode       (st_reg.mode),
        .i_col        (st_reg.col),
        .i_page       (st_reg.page),
        .i_col_start  (st_reg.col_start),
        .i_col_end    (st_reg.col_end),
        .i_page_start (st_reg.page_start),
        .i_page_end   (st_reg.page_end),
        .o_col        (step_col),
        .o_page       (step_page)
    );

    // Access classification
    assign wbyte   = i_serial_mode ? i_ser_data : i_data;
    assign cmd_wr  = wr_p && !i_dc;
    assign dat_wr  = wr_p && i_dc;
    assign dat_rd  = rd_p && i_dc;
    assign stat_rd = rd_p && !i_dc;

    // Parameter bytes per multi-byte opcode
    function automatic logic [2:0] param_count(input logic [7:0] op);
        case (op)
            DPA_OP_MODE, DPA_OP_CONTRAST, 8'ha8, 8'hd3, 8'hd5, 8'hd9, 8'hda, 8'hdb: param_count = 3'h1;
            DPA_OP_COLWIN, DPA_OP_PAGEWIN, 8'ha3: param_count = 3'h2;
            8'h29, 8'h2a:                         param_count = 3'h5;
            8'h26, 8'h27:                         param_count = 3'h6;
            default:                              param_count = 3'h0;
        endcase
    endfunction

    // -------------------------------------------------------------
    // Next state
    // -------------------------------------------------------------
    always_comb begin
        st_next         = st_reg;
        st_next.ram_we  = 1'b0;
        st_next.ram_re  = 1'b0;
        st_next.re_pend = st_reg.ram_re;
        st_next.dout_oe = rd_act;
        // Fetched RAM byte lands in the read buffer
        if (st_reg.re_pend) begin
            st_next.rd_buf = i_ram_rdata;
        end
        // Command byte, opcode phase
        if (cmd_wr && st_reg.cst == DPA_CMD_OPCODE) begin
            st_next.op   = wbyte;
            st_next.pidx = 3'h0;
            st_next.ptot = param_count(wbyte);
            if (param_count(wbyte) != 3'h0) begin
                st_next.cst = DPA_CMD_PARAM;
            end
            if (wbyte <= DPA_OP_LOCOL_HI) begin
                st_next.col[3:0] = wbyte[3:0];
            end else if (wbyte >= DPA_OP_HICOL_LO && wbyte <= DPA_OP_HICOL_HI) begin
                st_next.col[6:4] = wbyte[2:0];
            end else if (wbyte >= DPA_OP_PAGE_LO && wbyte <= DPA_OP_PAGE_HI) begin
                st_next.page = wbyte[2:0];
            end else if (wbyte >= DPA_OP_LINE_LO && wbyte <= DPA_OP_LINE_HI) begin
                st_next.line = wbyte[5:0];
            end else if (wbyte == DPA_OP_DISP_OFF || wbyte == DPA_OP_DISP_ON) begin
                st_next.disp_on = wbyte[0];
            end
            // NOP and unknown opcodes fall through with no effect
        end
        // Command byte, parameter phase; data bytes never count
        if (cmd_wr && st_reg.cst == DPA_CMD_PARAM) begin
            st_next.pidx = st_reg.pidx + 3'h1;
            if (st_reg.pidx == 3'h0) begin
                st_next.p1 = wbyte;
            end
            if (st_reg.pidx + 3'h1 == st_reg.ptot) begin
                st_next.cst = DPA_CMD_OPCODE;
                case (st_reg.op)
                    DPA_OP_MODE: begin
                        if (wbyte[1:0] != DPA_MODE_BAD) begin
                            st_next.mode = wbyte[1:0];
                        end
                    end
                    DPA_OP_COLWIN: begin
                        st_next.col_start = st_reg.p1[6:0];
                        st_next.col_end   = wbyte[6:0];
                        st_next.col       = st_reg.p1[6:0];
                    end
                    DPA_OP_PAGEWIN: begin
                        st_next.page_start = st_reg.p1[2:0];
                        st_next.page_end   = wbyte[2:0];
                        st_next.page       = st_reg.p1[2:0];
                    end
                    DPA_OP_CONTRAST: begin
                        st_next.contrast = wbyte;
                    end
                    default: begin
                        st_next.cst = DPA_CMD_OPCODE;
                    end
                endcase
            end
        end
        // Data write: store at pointer, then advance
        if (dat_wr) begin
            st_next.ram_we    = 1'b1;
            st_next.ram_col   = st_reg.col;
            st_next.ram_page  = st_reg.page;
            st_next.ram_wdata = wbyte;
            st_next.col       = step_col;
            st_next.page      = step_page;
        end
        // Data read: hand out the buffer, prefetch at pointer
        if (dat_rd) begin
            st_next.dout     = st_reg.rd_buf;
            st_next.ram_re   = 1'b1;
            st_next.ram_col  = st_reg.col;
            st_next.ram_page = st_reg.page;
            st_next.col      = step_col;
            st_next.page     = step_page;
        end
        // Status read leaves pointers alone
        if (stat_rd) begin
            st_next.dout = 8'h00;
            st_next.dout[DPA_STAT_OFF_BIT] = !st_reg.disp_on;
        end
    end

    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            st_reg            <= '0;
            st_reg.cst        <= DPA_CMD_OPCODE;
            st_reg.mode       <= DPA_MODE_PAGE;
            st_reg.col_end    <= DPA_COL_LAST;
            st_reg.page_end   <= DPA_PAGE_LAST;
            st_reg.line       <= DPA_RST_LINE;
            st_reg.contrast   <= DPA_RST_CONTRAST;
        end else begin
            st_reg <= st_next;
        end
    end

    // Outputs from flops
    assign o_data       = st_reg.dout;
    assign o_data_oe    = st_reg.dout_oe;
    assign o_ram_we     = st_reg.ram_we;
    assign o_ram_re     = st_reg.ram_re;
    assign o_ram_col    = st_reg.ram_col;
    assign o_ram_page   = st_reg.ram_page;
    assign o_ram_wdata  = st_reg.ram_wdata;
    assign o_addr_mode  = st_reg.mode;
    assign o_start_line = st_reg.line;
    assign o_contrast   = st_reg.contrast;
    assign o_display_on = st_reg.disp_on;

    // -------------------------------------------------------------
    // Assertions
    // -------------------------------------------------------------
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (!i_rst_n);

    logic opc;
    assign opc = cmd_wr && st_reg.cst == DPA_CMD_OPCODE;

    a_nop_no_change: assert property (opc && wbyte == DPA_OP_NOP |=>
        $stable(st_reg.col) && $stable(st_reg.page) && $stable(st_reg.line) && $stable(st_reg.disp_on))
        else $error("nop changed state");
    a_status_bit: assert property (stat_rd |=> o_data == {1'b0, !$past(st_reg.disp_on), 6'h00})
        else $error("status byte wrong");
    a_serial_no_read: assert property (i_serial_mode |=> !o_ram_re)
        else $error("read in serial mode");
    a_read_dummy: assert property (dat_rd ##1 1'b1 |-> o_data == $past(st_reg.rd_buf) && o_ram_re)
        else $error("read buffer not returned");
    a_write_store: assert property (dat_wr |=> o_ram_we && o_ram_col == $past(st_reg.col))
        else $error("write not stored at pointer");
    a_stat_no_move: assert property (stat_rd && !wr_p |=> $stable(st_reg.col) && $stable(st_reg.page))
        else $error("status read moved pointer");
    a_page_wrap: assert property (rd_p && i_dc && st_reg.mode == DPA_MODE_PAGE
        && st_reg.col == st_reg.col_end |=> st_reg.col == $past(st_reg.col_start) && $stable(st_reg.page))
        else $error("page mode wrap wrong");
    a_horiz_step: assert property (dat_wr && st_reg.mode == DPA_MODE_HORIZ && st_reg.col != st_reg.col_end
        |=> st_reg.col == $past(st_reg.col) + 7'h01 && $stable(st_reg.page))
        else $error("horizontal step wrong");
    a_vert_step: assert property (dat_wr && st_reg.mode == DPA_MODE_VERT && st_reg.page != st_reg.page_end
        |=> st_reg.page == $past(st_reg.page) + 3'h1 && $stable(st_reg.col))
        else $error("vertical step wrong");
    a_col_window: assert property (cmd_wr && st_reg.cst == DPA_CMD_PARAM && st_reg.op == DPA_OP_COLWIN
        && st_reg.pidx == 3'h1 |=> st_reg.col == st_reg.col_start
        && st_reg.col_start == 7'($past(st_reg.p1)) && st_reg.col_end == 7'($past(wbyte)))
        else $error("column window not loaded");
    a_line_set: assert property (opc && wbyte >= DPA_OP_LINE_LO && wbyte <= DPA_OP_LINE_HI
        |=> o_start_line == 6'($past(wbyte)))
        else $error("start line not set");
    a_mode_bad: assert property (cmd_wr && st_reg.cst == DPA_CMD_PARAM && st_reg.op == DPA_OP_MODE
        && wbyte[1:0] == DPA_MODE_BAD |=> $stable(o_addr_mode))
        else $error("invalid mode accepted");

    c_data_write: cover property (dat_wr ##1 o_ram_we);
    c_two_reads:  cover property (dat_rd ##[1:20] dat_rd);
    c_contrast:   cover property (opc && wbyte == DPA_OP_CONTRAST ##[1:10] $changed(o_contrast));
    c_horiz_wrap: cover property (dat_wr && st_reg.mode == DPA_MODE_HORIZ && st_reg.col == st_reg.col_end);
endmodule
`default_nettype wire

// [verification/dpa_ram_model.sv]
// Behavioural display RAM on the far side of the core's RAM port.
// Assumes reads answer one cycle after the read pulse, as the core expects.
`timescale 1ns/1ps
`default_nettype none
module dpa_ram_model (
    // Clock
    input  wire logic       i_core_clk,
    // Access port
    input  wire logic       i_we,
    input  wire logic       i_re,
    input  wire logic [6:0] i_col,
    input  wire logic [2:0] i_page,
    input  wire logic [7:0] i_wdata,
    output logic      [7:0] o_rdata
);
    logic [7:0] mem [0:1023];
    logic [7:0] rdata_reg = 8'h5a;

    // Store writes; read data is valid only the cycle after a read pulse
    always @(posedge i_core_clk) begin
        if (i_we) begin
            mem[{i_page, i_col}] <= i_wdata;
        end
        if (i_re) begin
            rdata_reg <= mem[{i_page, i_col}];
        end else begin
            rdata_reg <= ~rdata_reg; // Stale data never looks valid
        end
    end
    assign o_rdata = rdata_reg;
endmodule
`default_nettype wire

// [verification/display_ram_access_pointer_test.sv]
// Self-checking bench for dpa_core with a behavioural RAM behind it.
// Assumes 8080 strobes by default; inputs change on the falling edge.
`timescale 1ns/1ps
`default_nettype none
module display_ram_access_pointer_test;
    import dpa_pkg::*;
    typedef struct {logic [1:0] m; logic [6:0] cs, ce; logic [2:0] ps, pe; int n; logic [6:0] ec; logic [2:0] ep;} dpa_row_t;
    logic clk, rst_n, ser, b8080, cs_n, dc, rw, e, wr_n, rd_n, sv, we, re, oe, don;
    logic [7:0] din, sd, dout, wdata, rdata, con, q, qoe;
    logic [6:0] col;
    logic [2:0] page;
    logic [1:0] mode;
    logic [5:0] line;
    int error_cnt = 0;
    int compares = 0;
    dpa_row_t rows [5] = '{'{DPA_MODE_HORIZ, 5, 6, 1, 2, 5, 5, 1}, '{DPA_MODE_HORIZ, 5, 6, 1, 2, 3, 5, 2},
        '{DPA_MODE_VERT, 5, 6, 1, 2, 3, 6, 1}, '{DPA_MODE_VERT, 5, 6, 1, 2, 5, 5, 1},
        '{DPA_MODE_PAGE, 125, 127, 3, 3, 4, 125, 3}};

    dpa_core dut (.i_core_clk(clk), .i_rst_n(rst_n), .i_serial_mode(ser), .i_bus_8080(b8080), .i_cs_n(cs_n),
        .i_dc(dc), .i_rw(rw), .i_e(e), .i_wr_n(wr_n), .i_rd_n(rd_n), .i_data(din), .o_data(dout), .o_data_oe(oe),
        .i_ser_valid(sv), .i_ser_data(sd), .o_ram_we(we), .o_ram_re(re), .o_ram_col(col), .o_ram_page(page),
        .o_ram_wdata(wdata), .i_ram_rdata(rdata), .o_addr_mode(mode), .o_start_line(line), .o_contrast(con),
        .o_display_on(don));
    dpa_ram_model ram (.i_core_clk(clk), .i_we(we), .i_re(re), .i_col(col), .i_page(page), .i_wdata(wdata),
        .o_rdata(rdata));

    // Clock
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    // ----------------------------------------
    // Tasks
    // ----------------------------------------
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp) begin
            error_cnt++;
            $display("BAD %0t got %h expected %h", $time, got, exp);
        end
    endtask

    // One host write; outputs are settled when it returns
    task automatic wr(input logic c, input logic [7:0] d);
        @(negedge clk);
        dc = c;
        din = d;
        wr_n = 1'b0;
        @(negedge clk);
        wr_n = 1'b1;
        @(negedge clk);
        chk(8'(we), 8'(c));
        @(negedge clk);
    endtask

    // One host read with select high for data, low for status
    task automatic rd(input logic c, output logic [7:0] v, output logic [7:0] v_oe);
        @(negedge clk);
        dc = c;
        rd_n = 1'b0;
        @(negedge clk);
        v_oe = {6'h00, re, oe};
        rd_n = 1'b1;
        @(negedge clk);
        v = dout;
        repeat (2) @(negedge clk);
    endtask

    task automatic close_out();
        $display("Mismatches %0d of %0d compares", error_cnt, compares);
        if (error_cnt == 0 && compares > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // Watchdog
    initial begin
        repeat (3000) @(posedge clk);
        error_cnt++;
        close_out();
    end

    // Main sequence
    initial begin
        {rst_n, ser, dc, rw, e, sv, cs_n} = '0;
        {b8080, wr_n, rd_n} = 3'b111;
        din = 8'h00;
        sd = 8'h00;
        repeat (6) @(negedge clk);
        rst_n = 1'b1;
        chk(8'(mode), 8'(DPA_MODE_PAGE));
        chk(con, DPA_RST_CONTRAST);
        foreach (rows[r]) begin
            wr(0, DPA_OP_MODE);
            wr(0, 8'(rows[r].m));
            wr(0, DPA_OP_COLWIN);
            wr(0, 8'(rows[r].cs));
            wr(0, 8'(rows[r].ce));
            wr(0, DPA_OP_PAGEWIN);
            wr(0, 8'(rows[r].ps));
            wr(0, 8'(rows[r].pe));
            chk(8'(mode), 8'(rows[r].m));
            for (int i = 0; i < rows[r].n; i++) wr(1, 8'(i));
            chk(8'(col), 8'(rows[r].ec));
            chk(8'(page), 8'(rows[r].ep));
            chk(wdata, 8'(rows[r].n - 1));
        end
        // Page-mode pointer set by single-byte commands
        wr(0, DPA_OP_COLWIN);
        wr(0, 8'h00);
        wr(0, 8'h7f);
        wr(0, 8'hb3);
        wr(0, 8'h0a);
        wr(0, 8'h15);
        wr(1, 8'h11);
        chk(8'(col), 8'h5a);
        chk(8'(page), 8'h03);
        wr(0, DPA_OP_NOP);
        wr(1, 8'h22);
        chk(8'(col), 8'h5b);
        rd(0, q, qoe);
        chk(q, 8'h40);
        wr(0, DPA_OP_DISP_ON);
        chk(8'(don), 8'h01);
        cs_n = 1'b1;
        wr(0, DPA_OP_DISP_OFF);
        cs_n = 1'b0;
        rd(0, q, qoe);
        chk(q, 8'h00);
        wr(1, 8'h33);
        chk(8'(col), 8'h5c);
        // Reads after a pointer load: dummy first
        wr(0, DPA_OP_COLWIN);
        wr(0, 8'h5a);
        wr(0, 8'h7f);
        rd(1, q, qoe);
        rd(1, q, qoe);
        chk(q, 8'h11);
        chk(qoe, 8'h03);
        rd(1, q, qoe);
        chk(q, 8'h22);
        wr(1, 8'h44);
        chk(8'(col), 8'h5d);
        // Settings, invalid mode, data bytes inside parameters
        wr(0, DPA_OP_MODE);
        wr(0, 8'h03);
        chk(8'(mode), 8'(DPA_MODE_PAGE));
        wr(0, DPA_OP_LINE_HI);
        chk(8'(line), 8'd38);
        wr(0, DPA_OP_CONTRAST);
        wr(1, 8'h55);
        wr(0, 8'hff);
        chk(con, 8'hff);
        // 6800 strobes: write on enable fall, read on enable rise
        b8080 = 1'b0;
        @(negedge clk);
        {dc, rw, din, e} = {1'b1, 1'b0, 8'h66, 1'b1};
        @(negedge clk);
        e = 1'b0;
        @(negedge clk);
        chk({we, col}, {1'b1, 7'h5f});
        rw = 1'b1;
        e = 1'b1;
        @(negedge clk);
        e = 1'b0;
        chk(8'(oe), 8'h01);
        chk(dout, 8'h33);
        chk({re, col}, {1'b1, 7'h60});
        @(negedge clk);
        rw = 1'b0;
        // Serial port: no reads, writes only
        ser = 1'b1;
        rd(1, q, qoe);
        chk(qoe, 8'h00);
        @(negedge clk);
        dc = 1'b1;
        sd = 8'h77;
        sv = 1'b1;
        @(negedge clk);
        sv = 1'b0;
        chk({we, col}, {1'b1, 7'h61});
        chk(wdata, 8'h77);
        close_out();
    end
endmodule
`default_nettype wire
